/* File: logic/hac_pkg.sv */
package hac_pkg;
   // register map of the controller, byte addresses on the AXI4-Lite bus
   localparam logic [3:0]  HAC_OFF_CMD      = 4'h0;
   localparam logic [3:0]  HAC_OFF_STAT     = 4'h4;
   localparam logic [3:0]  HAC_OFF_SHADOW   = 4'h8;
   localparam logic [3:0]  HAC_OFF_DIV      = 4'hC;
   // command register fields
   localparam int          HAC_CMD_SEL_BIT  = 7;
   localparam int          HAC_CMD_ZERO_BIT = 3;
   localparam int          HAC_CMD_RD_BIT   = 8;
   // status register fields
   localparam int          HAC_ST_BUSY      = 0;
   localparam int          HAC_ST_ADDR_NACK = 1;
   localparam int          HAC_ST_DATA_NACK = 2;
   localparam int          HAC_ST_DROP      = 3;
   localparam int          HAC_ST_DONE      = 4;
   // shadow register field position of the volume copy
   localparam int          HAC_SHD_VOL_LSB  = 8;
   // device address on the serial bus
   localparam logic [6:0]  HAC_DEV_ADDR     = 7'h60;
   localparam logic [3:0]  HAC_ACK_BIT      = 4'h8;
   // serial clock limit and core clock rate
   localparam int          HAC_SCL_MAX_KHZ  = 400;
   localparam int          HAC_CLK_MHZ      = 125;
   // quarter of the shortest serial clock period, rounded up to whole cycles
   localparam int          HAC_QTR_CYC      = (HAC_CLK_MHZ * 1000 + 4 * HAC_SCL_MAX_KHZ - 1)
                                              / (4 * HAC_SCL_MAX_KHZ);
   localparam int          HAC_DIV_W        = 16;
   localparam logic [15:0] HAC_DIV_RST      = 16'(HAC_QTR_CYC);
   localparam logic [6:0]  HAC_SHADOW_RST   = 7'h00;
   localparam logic [1:0]  HAC_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  HAC_RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {
      HAC_IDLE  = 2'b00,
      HAC_START = 2'b01,
      HAC_BYTE  = 2'b10,
      HAC_STOP  = 2'b11
   } hac_state_t;
endpackage

/* File: logic/hac_tick_gen.sv */
`timescale 1ns/1ps
module hac_tick_gen #(
   parameter int W = 16
) (
   input  wire logic         clk_in,    // core clock
   input  wire logic         rst_n_in,  // synchronous reset, active low
   input  wire logic         run_in,    // counts only while high
   input  wire logic [W-1:0] div_in,    // cycles between ticks
   output logic              tick_out   // one-cycle enable
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !run_in) begin
         cnt_r    <= '0;
         tick_out <= 1'b0;
      end else if (cnt_r >= div_in - W'(1)) begin
         cnt_r    <= '0;
         tick_out <= 1'b1;
      end else begin
         cnt_r    <= cnt_r + W'(1);
         tick_out <= 1'b0;
      end
   end
endmodule // hac_tick_gen

/* File: logic/hac_i2c_host.sv */
// Overview of operation
// - host alone drives the serial clock, never faster than 400 kHz
// - outside START and STOP, data line only changes while the serial clock is low
// - each transfer opens with START and closes with STOP
// - every byte is 8 bits followed by one acknowledge clock
// - address 1100000 is sent MSB first, then the read/write bit
// - host releases data line for the address acknowledge clock
// - host sends one data byte after an acknowledged write address
// - after the data acknowledge, data rises while clock is high
// - data bit 7 picks mode (0) or volume (1) register
// - mode register bit 3 is always written as zero
`timescale 1ns/1ps
module hac_i2c_host
   import hac_pkg::*;
(
   input  wire logic        core_clk_in,          // 125 MHz core clock
   input  wire logic        rst_n_in,             // synchronous reset, active low
   input  wire logic        s_axi_awvalid_in,     // write address valid
   output logic             s_axi_awready_out,    // write address ready
   input  wire logic [31:0] s_axi_awaddr_in,      // write address
   input  wire logic        s_axi_wvalid_in,      // write data valid
   output logic             s_axi_wready_out,     // write data ready
   input  wire logic [31:0] s_axi_wdata_in,       // write data
   input  wire logic [3:0]  s_axi_wstrb_in,       // write byte enables
   output logic             s_axi_bvalid_out,     // write response valid
   input  wire logic        s_axi_bready_in,      // write response ready
   output logic [1:0]       s_axi_bresp_out,      // write response
   input  wire logic        s_axi_arvalid_in,     // read address valid
   output logic             s_axi_arready_out,    // read address ready
   input  wire logic [31:0] s_axi_araddr_in,      // read address
   output logic             s_axi_rvalid_out,     // read data valid
   input  wire logic        s_axi_rready_in,      // read data ready
   output logic [31:0]      s_axi_rdata_out,      // read data
   output logic [1:0]       s_axi_rresp_out,      // read response
   output logic             scl_out,              // serial clock to device
   input  wire logic        sda_in,               // serial data line level
   output logic             sda_out,              // serial data drive value
   output logic             sda_oe_n_out,         // low while pulling data low
   output logic             busy_out              // transfer in progress
);
   hac_state_t       state_r;
   logic [1:0]       phase_r;
   logic [3:0]       bit_r;
   logic [7:0]       shift_r;
   logic [7:0]       data_hold_r;
   logic             is_addr_r;
   logic             rd_r;
   logic             nack_r;
   logic             sda_meta_r;
   logic             sda_sync_r;
   logic             tick;
   logic [15:0]      div_r;
   logic [15:0]      div_eff;
   logic [8:0]       cmd_r;
   logic             go_r;
   logic             drop_r;
   logic             addr_nack_r;
   logic             data_nack_r;
   logic             done_r;
   logic             end_evt;
   logic [6:0]       mode_shd_r;
   logic [6:0]       vol_shd_r;
   logic             aw_got_r;
   logic             w_got_r;
   logic [3:0]       aw_addr_r;
   logic             aw_hi_r;
   logic [31:0]      w_data_r;
   logic [3:0]       w_strb_r;
   logic             wr_do;
   logic [31:0]      rd_nxt;
   logic [1:0]       rresp_nxt;

   // device pins: data is only ever pulled low
   assign sda_out = 1'b0;

   // never let software push the serial clock past its limit
   assign div_eff = (div_r < HAC_DIV_RST) ? HAC_DIV_RST : div_r;

   hac_tick_gen #(
      .W        (HAC_DIV_W)
   ) u_tick (
      .clk_in   (core_clk_in),
      .rst_n_in (rst_n_in),
      .run_in   (state_r != HAC_IDLE),
      .div_in   (div_eff),
      .tick_out (tick)
   );

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sda_meta_r <= 1'b1;
         sda_sync_r <= 1'b1;
      end else begin
         sda_meta_r <= sda_in;
         sda_sync_r <= sda_meta_r;
      end
   end

   // write address and write data taken independently, answered together
   assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid_out;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         aw_got_r          <= 1'b0;
         w_got_r           <= 1'b0;
         aw_addr_r         <= 4'h0;
         aw_hi_r           <= 1'b0;
         w_data_r          <= 32'h0000_0000;
         w_strb_r          <= 4'h0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_got_r          <= 1'b1;
            aw_addr_r         <= s_axi_awaddr_in[3:0];
            aw_hi_r           <= |s_axi_awaddr_in[31:4];
            s_axi_awready_out <= 1'b0;
         end else if (!aw_got_r) begin
            s_axi_awready_out <= 1'b1;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_got_r          <= 1'b1;
            w_data_r         <= s_axi_wdata_in;
            w_strb_r         <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end else if (!w_got_r) begin
            s_axi_wready_out <= 1'b1;
         end
         if (s_axi_bvalid_out && s_axi_bready_in) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= HAC_RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid_out <= 1'b1;
         if (!aw_hi_r && (aw_addr_r == HAC_OFF_CMD || aw_addr_r == HAC_OFF_STAT ||
                          aw_addr_r == HAC_OFF_SHADOW || aw_addr_r == HAC_OFF_DIV)) begin
            s_axi_bresp_out <= HAC_RESP_OKAY;
         end else begin
            s_axi_bresp_out <= HAC_RESP_SLVERR;
         end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   // command and divider registers; a command while busy is dropped
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         cmd_r  <= 9'h000;
         go_r   <= 1'b0;
         div_r  <= HAC_DIV_RST;
         drop_r <= 1'b0;
      end else begin
         go_r <= 1'b0;
         if (wr_do && !aw_hi_r && aw_addr_r == HAC_OFF_CMD && w_strb_r[0]) begin
            if (busy_out || go_r) begin
               drop_r <= 1'b1;
            end else begin
               cmd_r <= w_data_r[8:0];
               go_r  <= 1'b1;
            end
         end else if (wr_do && !aw_hi_r && aw_addr_r == HAC_OFF_STAT && w_strb_r[0] &&
                      w_data_r[HAC_ST_DROP]) begin
            drop_r <= 1'b0;
         end
         if (wr_do && !aw_hi_r && aw_addr_r == HAC_OFF_DIV) begin
            if (w_strb_r[0]) begin
               div_r[7:0] <= w_data_r[7:0];
            end
            if (w_strb_r[1]) begin
               div_r[15:8] <= w_data_r[15:8];
            end
         end
      end
   end

   always_comb begin
      rd_nxt    = 32'h0000_0000;
      rresp_nxt = HAC_RESP_OKAY;
      if (|s_axi_araddr_in[31:4]) begin
         rresp_nxt = HAC_RESP_SLVERR;
      end else if (s_axi_araddr_in[3:0] == HAC_OFF_CMD) begin
         rd_nxt[8:0] = cmd_r;
      end else if (s_axi_araddr_in[3:0] == HAC_OFF_STAT) begin
         rd_nxt[HAC_ST_BUSY]      = busy_out;
         rd_nxt[HAC_ST_ADDR_NACK] = addr_nack_r;
         rd_nxt[HAC_ST_DATA_NACK] = data_nack_r;
         rd_nxt[HAC_ST_DROP]      = drop_r;
         rd_nxt[HAC_ST_DONE]      = done_r;
      end else if (s_axi_araddr_in[3:0] == HAC_OFF_SHADOW) begin
         rd_nxt[6:0]                              = mode_shd_r;
         rd_nxt[HAC_SHD_VOL_LSB+6:HAC_SHD_VOL_LSB] = vol_shd_r;
      end else if (s_axi_araddr_in[3:0] == HAC_OFF_DIV) begin
         rd_nxt[15:0] = div_r;
      end else begin
         rresp_nxt = HAC_RESP_SLVERR;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= 32'h0000_0000;
         s_axi_rresp_out   <= HAC_RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b1;
         s_axi_rdata_out   <= rd_nxt;
         s_axi_rresp_out   <= rresp_nxt;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end else if (!s_axi_rvalid_out) begin
         s_axi_arready_out <= 1'b1;
      end
   end

   // serial engine: four quarter-period steps per bit
   assign end_evt = tick && state_r == HAC_STOP && phase_r == 2'd3;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         state_r      <= HAC_IDLE;
         phase_r      <= 2'd0;
         bit_r        <= 4'h0;
         shift_r      <= 8'h00;
         data_hold_r  <= 8'h00;
         is_addr_r    <= 1'b1;
         rd_r         <= 1'b0;
         nack_r       <= 1'b0;
         scl_out      <= 1'b1;
         sda_oe_n_out <= 1'b1;
         busy_out     <= 1'b0;
      end else begin
         case (state_r)
            HAC_IDLE: begin
               scl_out      <= 1'b1;
               sda_oe_n_out <= 1'b1;
               if (go_r) begin
                  state_r   <= HAC_START;
                  phase_r   <= 2'd0;
                  busy_out  <= 1'b1;
                  is_addr_r <= 1'b1;
                  rd_r      <= cmd_r[HAC_CMD_RD_BIT];
                  shift_r   <= {HAC_DEV_ADDR, cmd_r[HAC_CMD_RD_BIT]};
                  data_hold_r <= cmd_r[7:0];
                  if (!cmd_r[HAC_CMD_SEL_BIT]) begin
                     data_hold_r[HAC_CMD_ZERO_BIT] <= 1'b0;
                  end
               end
            end
            HAC_START: begin
               if (tick) begin
                  phase_r <= phase_r + 2'd1;
                  if (phase_r == 2'd0) begin
                     sda_oe_n_out <= 1'b0;
                  end else if (phase_r == 2'd2) begin
                     scl_out <= 1'b0;
                  end else if (phase_r == 2'd3) begin
                     state_r <= HAC_BYTE;
                     bit_r   <= 4'h0;
                  end
               end
            end
            HAC_BYTE: begin
               if (tick) begin
                  phase_r <= phase_r + 2'd1;
                  if (phase_r == 2'd0) begin
                     // released for the acknowledge clock
                     sda_oe_n_out <= (bit_r == HAC_ACK_BIT) ? 1'b1 : shift_r[7];
                  end else if (phase_r == 2'd1) begin
                     scl_out <= 1'b1;
                  end else if (phase_r == 2'd2) begin
                     if (bit_r == HAC_ACK_BIT) begin
                        nack_r <= sda_sync_r;
                     end else begin
                        shift_r <= {shift_r[6:0], 1'b0};
                     end
                  end else begin
                     scl_out <= 1'b0;
                     if (bit_r != HAC_ACK_BIT) begin
                        bit_r <= bit_r + 4'h1;
                     end else if (nack_r || !is_addr_r || rd_r) begin
                        state_r <= HAC_STOP;
                     end else begin
                        shift_r   <= data_hold_r;
                        is_addr_r <= 1'b0;
                        bit_r     <= 4'h0;
                     end
                  end
               end
            end
            HAC_STOP: begin
               if (tick) begin
                  phase_r <= phase_r + 2'd1;
                  if (phase_r == 2'd0) begin
                     sda_oe_n_out <= 1'b0;
                  end else if (phase_r == 2'd1) begin
                     scl_out <= 1'b1;
                  end else if (phase_r == 2'd2) begin
                     sda_oe_n_out <= 1'b1;
                  end else begin
                     state_r  <= HAC_IDLE;
                     busy_out <= 1'b0;
                  end
               end
            end
            default: begin
               state_r <= HAC_IDLE;
            end
         endcase
      end
   end

   // outcome flags and the host's copy of the device registers
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         addr_nack_r <= 1'b0;
         data_nack_r <= 1'b0;
         done_r      <= 1'b0;
         mode_shd_r  <= HAC_SHADOW_RST;
         vol_shd_r   <= HAC_SHADOW_RST;
      end else if (go_r && state_r == HAC_IDLE) begin
         addr_nack_r <= 1'b0;
         data_nack_r <= 1'b0;
         done_r      <= 1'b0;
      end else if (tick && state_r == HAC_BYTE && phase_r == 2'd3 && bit_r == HAC_ACK_BIT) begin
         if (is_addr_r) begin
            addr_nack_r <= nack_r;
         end else begin
            data_nack_r <= nack_r;
            if (!nack_r && data_hold_r[HAC_CMD_SEL_BIT]) begin
               vol_shd_r <= data_hold_r[6:0];
            end else if (!nack_r) begin
               mode_shd_r <= data_hold_r[6:0];
            end
         end
      end else if (end_evt) begin
         done_r <= 1'b1;
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   property p_scl_slow;
      $rose(scl_out) |-> scl_out [*8];
   endproperty
   a_scl_slow: assert property (p_scl_slow) else $error("serial clock high too short");

   property p_sda_steady;
      (state_r == HAC_BYTE && scl_out && $past(scl_out)) |-> $stable(sda_oe_n_out);
   endproperty
   a_sda_steady: assert property (p_sda_steady) else $error("data moved, clock high");

   property p_start_edge;
      ($fell(sda_oe_n_out) && state_r == HAC_START) |-> scl_out;
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("start without clock high");

   property p_bit_range;
      state_r == HAC_BYTE |-> bit_r <= HAC_ACK_BIT;
   endproperty
   a_bit_range: assert property (p_bit_range) else $error("byte over nine clocks");

   property p_addr_load;
      (go_r && state_r == HAC_IDLE) |=> shift_r[7:1] == HAC_DEV_ADDR && state_r == HAC_START;
   endproperty
   a_addr_load: assert property (p_addr_load) else $error("wrong address loaded");

   property p_ack_release;
      (state_r == HAC_BYTE && bit_r == HAC_ACK_BIT && phase_r != 2'd0) |-> sda_oe_n_out;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("data driven in ack");

   property p_read_stops;
      (tick && state_r == HAC_BYTE && phase_r == 2'd3 && bit_r == HAC_ACK_BIT && rd_r)
         |=> state_r == HAC_STOP;
   endproperty
   a_read_stops: assert property (p_read_stops) else $error("read went past address");

   property p_mode_zero;
      (state_r == HAC_START && !data_hold_r[HAC_CMD_SEL_BIT]) |-> !data_hold_r[HAC_CMD_ZERO_BIT];
   endproperty
   a_mode_zero: assert property (p_mode_zero) else $error("mode bit 3 not zero");

   property p_stop_edge;
      ($rose(sda_oe_n_out) && state_r == HAC_STOP) |-> scl_out ##1 (state_r == HAC_STOP);
   endproperty
   a_stop_edge: assert property (p_stop_edge) else $error("stop without clock high");

   c_write_done: cover property (end_evt && !data_nack_r && !addr_nack_r && !rd_r);
   c_addr_nack: cover property (end_evt && addr_nack_r);
   c_read_refused: cover property (end_evt && rd_r);
   c_drop: cover property ($rose(drop_r));
endmodule // hac_i2c_host

/* File: verif/hac_dev_model.sv */
`timescale 1ns/1ps
module hac_dev_model (
   input  wire logic       scl_in,        // serial clock from host
   input  wire logic       sda_in,        // resolved data line
   input  wire logic       nack_data_in,  // refuse the data byte
   output logic            sda_oe_n_out,  // low while pulling data low
   output logic [6:0]      mode_out,      // channel_mode_ctrl bits 6..0
   output logic [6:0]      vol_out        // volume_power_ctrl bits 6..0
);
   logic [7:0] sh_r;
   int         cnt;
   logic       addr_ok;
   logic       in_data;
   initial begin
      sda_oe_n_out = 1'b1;
      mode_out = 7'h00;
      vol_out = 7'h00;
      cnt = -1;
   end
   always @(negedge sda_in) if (scl_in) begin // start resyncs
      cnt = 0;
      in_data = 1'b0;
      addr_ok = 1'b0;
   end
   always @(posedge sda_in) if (scl_in) cnt = -1; // stop
   always @(posedge scl_in) begin // slave only, never drives clock
      if (cnt >= 0 && cnt < 8) begin
         sh_r = {sh_r[6:0], sda_in};
         cnt++;
      end else if (cnt == 8) cnt = 9;
   end
   always @(negedge scl_in) begin
      if (cnt == 8) begin
         if (!in_data) addr_ok = (sh_r == 8'hC0);
         sda_oe_n_out = !(addr_ok && !(in_data && nack_data_in));
      end else if (cnt == 9) begin
         sda_oe_n_out = 1'b1;
         if (in_data && addr_ok && !nack_data_in) begin
            if (sh_r[7]) vol_out = sh_r[6:0];
            else mode_out = sh_r[6:0];
         end
         cnt = (addr_ok && !in_data) ? 0 : -1; // silent after a read bit
         in_data = 1'b1;
      end
   end
endmodule // hac_dev_model

/* File: verif/hac_i2c_host_tb_top.sv */
`timescale 1ns/1ps
module hac_i2c_host_tb_top;
   import hac_pkg::*;
   typedef struct {logic [8:0] cmd; logic nack; logic [6:0] mode, vol; logic [4:0] st;} hac_row_t;
   logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, nack = 0;
   logic [31:0] awa = 0, wd = 0, ara = 0, rd, rdat;
   logic        awr, wr, bv, arr, rv, scl, sdo, oe_n, busy, dev_oe_n, sda_w;
   logic [1:0]  br, rr, resp;
   logic [6:0]  dmode, dvol;
   int          err_total = 0, num_checks = 0;
   real         t_last = 0;
   hac_row_t    rows[6] = '{'{9'h07F, 0, 7'h77, 7'h00, 5'h10}, '{9'h0BF, 0, 7'h77, 7'h3F, 5'h10},
                            '{9'h0C0, 0, 7'h77, 7'h40, 5'h10}, '{9'h00F, 0, 7'h07, 7'h40, 5'h10},
                            '{9'h185, 0, 7'h07, 7'h40, 5'h12}, '{9'h005, 1, 7'h07, 7'h40, 5'h14}};
   assign sda_w = (oe_n ? 1'b1 : sdo) & dev_oe_n;
   always #4 clk = ~clk;
   hac_i2c_host dut (.core_clk_in(clk), .rst_n_in(rst_n), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .s_axi_rdata_out(rdat),
      .s_axi_rresp_out(rr), .scl_out(scl), .sda_in(sda_w), .sda_out(sdo),
      .sda_oe_n_out(oe_n), .busy_out(busy));
   hac_dev_model dev (.scl_in(scl), .sda_in(sda_w), .nack_data_in(nack),
      .sda_oe_n_out(dev_oe_n), .mode_out(dmode), .vol_out(dvol));
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t response %h expected %h", $time, got, exp);
      end
   endtask
   // waits as long as the slave takes; only the watchdog ends a hang
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      forever begin
         @(posedge clk);
         if (bv === 1'b1) begin
            r = br;
            break;
         end
         if (awr === 1'b1) awv <= 1'b0;
         if (wr === 1'b1) wv <= 1'b0;
      end
      bre <= 1'b0;
      // idle edge so a following call never re-raises bready in this step
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      forever begin
         @(posedge clk);
         if (rv === 1'b1) begin
            d = rdat;
            r = rr;
            break;
         end
         if (arr === 1'b1) arv <= 1'b0;
      end
      rre <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_idle();
      repeat (20) begin @(posedge clk); if (busy === 1'b1) break; end
      repeat (10000) begin @(posedge clk); if (busy === 1'b0) break; end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge scl) begin // clock no faster than 400 kHz
      if (t_last > 0) chk_val(32'($realtime - t_last >= 2500.0), 1);
      t_last = $realtime;
   end
   initial begin
      #600_000;
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk_val(scl, 1);
      chk_val(oe_n, 1);
      chk_val(sdo, 0);
      foreach (rows[i]) begin
         nack <= rows[i].nack;
         axi_wr(HAC_OFF_CMD, rows[i].cmd, resp);
         chk_resp(resp, HAC_RESP_OKAY);
         wait_idle();
         axi_rd(HAC_OFF_STAT, rd, resp);
         chk_val(rd, rows[i].st);
         axi_rd(HAC_OFF_SHADOW, rd, resp);
         chk_val(rd, {17'h0, rows[i].vol, 1'b0, rows[i].mode});
         chk_val(dmode, rows[i].mode);
         chk_val(dvol, rows[i].vol);
      end
      nack <= 1'b0;
      axi_wr(HAC_OFF_CMD, 32'h01, resp);
      axi_wr(HAC_OFF_CMD, 32'h02, resp);
      axi_rd(HAC_OFF_STAT, rd, resp);
      chk_val(rd[HAC_ST_DROP], 1);
      chk_val(rd[HAC_ST_BUSY], 1);
      chk_val(busy, 1);
      wait_idle();
      chk_val(dmode, 7'h01);
      axi_wr(HAC_OFF_STAT, 32'h08, resp);
      axi_rd(HAC_OFF_STAT, rd, resp);
      chk_val(rd[HAC_ST_DROP], 0);
      // a divider below the limit must still give a legal serial clock
      axi_wr(HAC_OFF_DIV, 32'h0000_0010, resp);
      chk_resp(resp, HAC_RESP_OKAY);
      axi_rd(HAC_OFF_DIV, rd, resp);
      chk_val(rd, 32'h0000_0010);
      axi_wr(HAC_OFF_CMD, 32'h0000_00C5, resp);
      wait_idle();
      chk_val(dvol, 7'h45);
      axi_rd(32'h40, rd, resp);
      chk_resp(resp, HAC_RESP_SLVERR);
      chk_val(rd, 0);
      axi_wr(32'h40, 32'h05, resp);
      chk_resp(resp, HAC_RESP_SLVERR);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      axi_rd(HAC_OFF_SHADOW, rd, resp);
      chk_val(rd, 0);
      axi_rd(HAC_OFF_DIV, rd, resp);
      chk_val(rd, {16'h0, HAC_DIV_RST});
      chk_val(dmode, 7'h01);
      end_of_test();
   end
endmodule // hac_i2c_host_tb_top
